// *** logic/cld_defs.vh ***
// constants for the channel load diagnosis block
`ifndef CLD_DEFS_VH
`define CLD_DEFS_VH
`define CLD_NCH            8
`define CLD_ADDR_CTRL      4'h0
`define CLD_ADDR_ERR       4'h1
`define CLD_ADDR_CLEAR     4'h2
`define CLD_ADDR_IOL       4'h3
`define CLD_ADDR_OSM       4'h4
`define CLD_ADDR_MUX       4'h5
`define CLD_ADDR_ON_OPEN_LOAD_SUMMARY      4'h6
`define CLD_ADDR_STD       4'h7
`define CLD_ADDR_HSCFG     4'h8
`define CLD_ADDR_PAR       4'h9
`define CLD_MUX_DEFAULT    4'hF
`define CLD_MUX_FIRST      4'h2
`define CLD_MUX_LAST       4'h7
`define CLD_STD_OFF_OPEN_LOAD_SUMMARY      0
`define CLD_STD_ON_OPEN_LOAD_SUMMARY       1
`define CLD_STD_ERR        2
`define CLD_CLK_HZ         10000000
`define CLD_OSM_US         20
`define CLD_OLONSET_US     50
`define CLD_OLONSET_CYC    ((`CLD_OLONSET_US * (`CLD_CLK_HZ / 1000000)))
`define CLD_RETRY0_MS      10
`define CLD_RETRY_CYC      ((`CLD_RETRY0_MS * (`CLD_CLK_HZ / 1000)))
`define CLD_RETRY_PER_STEP 3'h7
`define CLD_RETRY_LAST     2'h3
`define CLD_SYNC_CYC       2
`define CLD_RESP_OKAY      2'h0
`define CLD_RESP_SLVERR    2'h2
`endif

// *** logic/cld_restart.v ***
// fallback-mode restart timer for one channel
`timescale 1ns/1ns
`default_nettype none
`include "cld_defs.vh"
module cld_restart #(
  parameter [31:0] BASE_CYC = `CLD_RETRY_CYC
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // control
  input  wire        fallback,
  input  wire        in_sync,
  input  wire        fault,
  // result
  output reg         restart
);
  reg [35:0] cnt;
  reg [1:0]  step;
  reg [2:0]  nretry;
  reg [2:0]  low_cnt;
  reg        waiting;
  wire [35:0] limit = {4'h0, BASE_CYC} << step;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt     <= 36'h0;
      step    <= 2'h0;
      nretry  <= 3'h0;
      low_cnt <= 3'h0;
      waiting <= 1'b0;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (!in_sync) begin
        if (low_cnt <= `CLD_SYNC_CYC)
          low_cnt <= low_cnt + 3'h1;
        else begin
          step    <= 2'h0;
          nretry  <= 3'h0;
          waiting <= 1'b0;
          cnt     <= 36'h0;
        end
      end else begin
        low_cnt <= 3'h0;
      end
      if (fallback && in_sync && fault && !waiting) begin
        waiting <= 1'b1;
        cnt     <= 36'h0;
      end else if (waiting) begin
        if (cnt + 36'h1 >= limit) begin
          waiting <= 1'b0;
          restart <= 1'b1;
          if (nretry == `CLD_RETRY_PER_STEP) begin
            nretry <= 3'h0;
            if (step != `CLD_RETRY_LAST)
              step <= step + 2'h1;
          end else
            nretry <= nretry + 3'h1;
        end else
          cnt <= cnt + 36'h1;
      end
    end
  end
endmodule // cld_restart
`default_nettype wire

// *** logic/cld_top.v ***
// per-channel diagnosis logic with AXI4-Lite register access
// Function
// - each channel's diagnosis is independent, except paired parallel channels
// - over-load or over-temperature on a driven channel sets the channel error flag
// - faulted channel stays off until software writes 1 to latch clear bit or a fallback restart clears it
// - monitor bit is 1 for low-side low vds or high-side high output
// - output monitor sampled live and captured at each read of its own register
// - each channel has its own diagnosis current enable
// - open load never switches or latches a channel off
// - off open-load summary is OR of monitor bits, off channels with current
// - on-state open load only on high-side auto-configurable channels via select
// - on-state diagnosis inactive after reset until select field programmed
// - codes 0010 to 0111 select a channel, valid after settling time
// - unselected on-state open-load bits read as 0
// - on-state register refreshed on every read, also back to back
// - selected channel's on bit mirrors into on-state summary
// - fallback restart intervals 10, 20, 40, 80 ms
// - eight restarts per interval step, then 80 ms onward
// - input low for four cycles in a row resets the restart timer
// - reserved select codes hold on-state summary at 0
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cld_defs.vh"
module cld_top #(
  parameter [31:0] RETRY_CYC = `CLD_RETRY_CYC
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // channel commands (aclk domain) and fault sensing (asynchronous)
  input  wire [7:0]  chan_request,
  input  wire [7:0]  overload_pin,
  input  wire [7:0]  overtemp_pin,
  input  wire [7:0]  monitor_cmp_pin,
  input  wire [7:0]  load_current_low_pin,
  input  wire        fallback_pin,
  input  wire        fallback_in_pin,
  // channel drive
  output reg  [7:0]  chan_on,
  output reg  [7:0]  diag_current_enable,
  output reg  [2:0]  mux_channel,
  output reg         mux_enable
);
  // two-flop synchronisers, first stage read only by the second
  // chan_request comes from logic on aclk and skips these flops
  reg [33:0] sync_a;
  reg [33:0] sync_b;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 34'h0;
      sync_b <= 34'h0;
    end else begin
      sync_a <= {fallback_in_pin, fallback_pin, load_current_low_pin,
                 monitor_cmp_pin, overtemp_pin, overload_pin};
      sync_b <= sync_a;
    end
  end
  wire [7:0] ovl_s  = sync_b[7:0];
  wire [7:0] ovt_s  = sync_b[15:8];
  wire [7:0] cmp_s  = sync_b[23:16];
  wire [7:0] ilow_s = sync_b[31:24];
  wire       fb_s   = sync_b[32];
  wire       fbin_s = sync_b[33];

  // codes outside the channel range are reserved and select nothing
  function sel_valid;
    input [3:0] code;
    begin
      sel_valid = (code >= `CLD_MUX_FIRST) && (code <= `CLD_MUX_LAST);
    end
  endfunction
  // upper address bits must be zero; bits 1:0 are ignored, so byte offsets alias onto a register
  function addr_hit;
    input [31:0] a;
    input [3:0]  idx;
    begin
      addr_hit = (a[31:6] == 26'h0) && (a[5:2] == idx);
    end
  endfunction

  // software registers
  reg [7:0] channel_error_flag;
  reg [7:0] hs_config;
  reg [3:0] par_pairs;
  reg [3:0] on_diag_select_field;
  reg [7:0] output_monitor_register;
  reg [7:0] on_diag_done;
  reg [15:0] set_cnt;
  // fallback state is only reported here; the restart timers act on it
  reg       fallback_active;
  // comparator polarity folded into the analog pin; raw level is the bit
  wire [7:0] monitor_live = cmp_s;
  wire [7:0] fault_now    = ovl_s | ovt_s;
  // parallel pairs share one fault so both halves latch together
  wire [7:0] pair_fault;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
      assign pair_fault[2*gi]   = fault_now[2*gi]   | (par_pairs[gi] & fault_now[2*gi+1]);
      assign pair_fault[2*gi+1] = fault_now[2*gi+1] | (par_pairs[gi] & fault_now[2*gi]);
    end
  endgenerate

  // fallback restart timers
  // one timer per channel, so a stuck channel never delays the others
  wire [7:0] restart;
  generate
    for (gi = 0; gi < `CLD_NCH; gi = gi + 1) begin : g_rst
      cld_restart #(.BASE_CYC(RETRY_CYC)) u_rst (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .fallback (fb_s),
        .in_sync  (fbin_s),
        .fault    (channel_error_flag[gi]),
        .restart  (restart[gi])
      );
    end
  endgenerate

  // axi write path
  // address and data may arrive apart; the early one waits in a holding reg
  reg        aw_held;
  reg        w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_now  = w_held | (s_axi_wvalid & s_axi_wready);
  wire [31:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire do_wr = aw_now && w_now && !s_axi_bvalid;
  wire wr_clear = do_wr && addr_hit(wa, `CLD_ADDR_CLEAR) && ws[0];
  wire [7:0] clear_bits = wr_clear ? wd[7:0] : 8'h00;
  // a write without its low byte strobe is answered but changes nothing
  wire wr_known = addr_hit(wa, `CLD_ADDR_CTRL) || addr_hit(wa, `CLD_ADDR_CLEAR) ||
                  addr_hit(wa, `CLD_ADDR_IOL) || addr_hit(wa, `CLD_ADDR_MUX) ||
                  addr_hit(wa, `CLD_ADDR_HSCFG) || addr_hit(wa, `CLD_ADDR_PAR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CLD_RESP_OKAY;
      diag_current_enable <= 8'h00;
      on_diag_select_field <= `CLD_MUX_DEFAULT;
      hs_config <= 8'h00;
      par_pairs <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `CLD_RESP_OKAY : `CLD_RESP_SLVERR;
        if (ws[0]) begin
          if (addr_hit(wa, `CLD_ADDR_IOL))
            diag_current_enable <= wd[7:0];
          if (addr_hit(wa, `CLD_ADDR_MUX))
            on_diag_select_field <= wd[3:0];
          if (addr_hit(wa, `CLD_ADDR_HSCFG))
            hs_config <= wd[7:0];
          if (addr_hit(wa, `CLD_ADDR_PAR))
            par_pairs <= wd[3:0];
        end
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // error latch and channel drive; open load plays no part here
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_error_flag <= 8'h00;
      chan_on <= 8'h00;
      fallback_active <= 1'b0;
    end else begin
      fallback_active <= fb_s;
      // set beats a clear in the same cycle
      channel_error_flag <= (channel_error_flag & ~clear_bits & ~restart) |
                            (pair_fault & chan_on);
      // faults only latch while driven, so a channel held off cannot flag
      chan_on <= chan_request & ~channel_error_flag & ~(pair_fault & chan_on);
    end
  end

  // on-state mux routing and settling
  // any change of code, drive side or routing restarts the settling count
  wire       sel_ok = sel_valid(on_diag_select_field);
  wire [2:0] sel_ch = on_diag_select_field[2:0];
  wire       sel_hs = hs_config[sel_ch];
  always @(posedge aclk) begin
    if (!aresetn) begin
      mux_channel <= 3'h0;
      mux_enable <= 1'b0;
      set_cnt <= 16'h0;
      on_diag_done <= 8'h00;
    end else begin
      mux_channel <= sel_ch;
      mux_enable <= sel_ok && sel_hs;
      if (!(sel_ok && sel_hs) || mux_channel != sel_ch || !mux_enable) begin
        set_cnt <= 16'h0;
        on_diag_done <= 8'h00;
      end else if (set_cnt < `CLD_OLONSET_CYC)
        set_cnt <= set_cnt + 16'h1;
      else
        on_diag_done <= 8'h01 << sel_ch;
    end
  end
  // only the selected, settled bit may be nonzero
  wire [7:0] on_open_load_summary_live = on_diag_done & ilow_s & monitor_live & chan_on;
  wire off_open_load_summary = |(output_monitor_register & ~chan_on & diag_current_enable);
  wire on_open_load_summary_sum = sel_ok ? |on_open_load_summary_live : 1'b0;

  // axi read path
  // live bits are sampled in the cycle a read is taken, so back to back reads stay fresh
  assign s_axi_arready = !s_axi_rvalid;
  wire [31:0] ra = s_axi_araddr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CLD_RESP_OKAY;
      output_monitor_register <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CLD_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (addr_hit(ra, `CLD_ADDR_CTRL))
          s_axi_rdata <= {23'h0, fallback_active, chan_on};
        else if (addr_hit(ra, `CLD_ADDR_ERR))
          s_axi_rdata <= {24'h0, channel_error_flag};
        else if (addr_hit(ra, `CLD_ADDR_CLEAR))
          s_axi_rdata <= 32'h0;
        else if (addr_hit(ra, `CLD_ADDR_IOL))
          s_axi_rdata <= {24'h0, diag_current_enable};
        else if (addr_hit(ra, `CLD_ADDR_OSM)) begin
          output_monitor_register <= monitor_live;
          s_axi_rdata <= {24'h0, monitor_live};
        end else if (addr_hit(ra, `CLD_ADDR_MUX))
          s_axi_rdata <= {28'h0, on_diag_select_field};
        else if (addr_hit(ra, `CLD_ADDR_ON_OPEN_LOAD_SUMMARY)) begin
          s_axi_rdata <= {24'h0, on_open_load_summary_live};
        end else if (addr_hit(ra, `CLD_ADDR_STD)) begin
          // summary bits are formed at the read itself
          s_axi_rdata <= {29'h0, |channel_error_flag, on_open_load_summary_sum, off_open_load_summary};
        end else if (addr_hit(ra, `CLD_ADDR_HSCFG))
          s_axi_rdata <= {24'h0, hs_config};
        else if (addr_hit(ra, `CLD_ADDR_PAR))
          s_axi_rdata <= {28'h0, par_pairs};
        else
          s_axi_rresp <= `CLD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cld_top
`default_nettype wire

// *** testbench/cld_host.sv ***
// controller model: bus master that notes each expected answer
`timescale 1ns/1ns
`default_nettype none
module cld_host (
  // clock
  input  wire logic        aclk,
  // write side
  output logic [31:0] s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  // read side
  output logic [31:0] s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  logic [33:0] exp_q[$];
  logic [3:0]  strb = 4'hF;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    exp_q.push_back({er, 32'h0});
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !ad) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !wd) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // settling waits are the controller's duty, except the on-state mux settling the device times itself
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask
endmodule // cld_host
`default_nettype wire

// *** testbench/cld_top_asserts.sv ***
// port checker for the channel load diagnosis block
`timescale 1ns/1ns
`default_nettype none
module cld_top_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus responses
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // channels
  input wire logic [7:0]  chan_request,
  input wire logic [7:0]  overload_pin,
  input wire logic [7:0]  overtemp_pin,
  input wire logic [7:0]  chan_on,
  input wire logic        fallback_pin,
  input wire logic [2:0]  mux_channel,
  input wire logic        mux_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // recent reasons for a channel to drop; covers sync and latch latency
  logic [47:0] hist;
  wire  [7:0]  cause = overload_pin | overtemp_pin | ~chan_request | {8{fallback_pin}};
  wire  [7:0]  recent = cause | hist[7:0] | hist[15:8] | hist[23:16] | hist[31:24] | hist[39:32] | hist[47:40];
  always_ff @(posedge aclk) begin
    if (!aresetn) hist <= '1;
    else hist <= {hist[39:0], cause};
  end
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence hot; ((overload_pin | overtemp_pin) & chan_on) != 8'h0; endsequence
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without request");
  bad_addr_a: assert property (rd_take ##0 s_axi_araddr >= 32'h28 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  on_open_load_summary_other_a: assert property (rd_take ##0 (s_axi_araddr == 32'h18 && mux_enable) |=>
    (s_axi_rdata & ~(32'h1 << $past(mux_channel))) == 32'h0) else $error("unselected on bit set");
  mux_idle_a: assert property ($rose(aresetn) |-> !mux_enable [*8]) else $error("on diag active at reset");
  fault_off_a: assert property (hot |-> ##[1:8] ((overload_pin | overtemp_pin) & chan_on) == 8'h0)
    else $error("faulted channel kept on");
  keep_on_a: assert property (($past(chan_on) & ~chan_on & ~recent) == 8'h0)
    else $error("channel dropped without cause");
endmodule // cld_top_asserts
bind cld_top cld_top_asserts cld_top_asserts_inst (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .chan_request, .overload_pin, .overtemp_pin, .chan_on, .fallback_pin, .mux_channel, .mux_enable);
`default_nettype wire

// *** testbench/test_cld_top.sv ***
// self-checking bench for the channel load diagnosis block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module test_cld_top;
  localparam int RC = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fallback_pin, fallback_in_pin, mux_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  chan_request, overload_pin, overtemp_pin, monitor_cmp_pin, load_current_low_pin;
  logic [7:0]  chan_on, diag_current_enable, r, m, ll;
  logic [2:0]  mux_channel, ch;
  logic [33:0] e;
  logic        on0_q;
  int fails, n_compared, cyc, seed, edges[$];
  cld_top #(.RETRY_CYC(RC)) cld_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chan_request, .overload_pin, .overtemp_pin, .monitor_cmp_pin, .load_current_low_pin, .fallback_pin,
    .fallback_in_pin, .chan_on, .diag_current_enable, .mux_channel, .mux_enable);
  cld_host cld_host_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  task wrap_up;
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic gap_ok(input int g, input int nom);
    return g >= nom * 7 / 10 && g <= nom * 13 / 10 + 6;
  endfunction
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
    if (chan_on[0] && !on0_q) edges.push_back(cyc);
    on0_q <= chan_on[0];
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      e = cld_host_inst.exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      e = cld_host_inst.exp_q.pop_front();
      `CHK({s_axi_bresp, 32'h0}, e)
    end
  end
  initial begin
    seed = 32'h4454;
    {aresetn, chan_request, overload_pin, overtemp_pin, monitor_cmp_pin, load_current_low_pin} = '0;
    {fallback_pin, fallback_in_pin, cyc} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cld_host_inst.rd(32'h14, 34'hF);
    `CHK(mux_enable, 1'b0)
    cld_host_inst.rd(32'h4, 34'h0);
    cld_host_inst.rd(32'h40, 34'h200000000);
    cld_host_inst.wr(32'h40, 32'h1, 2'h2);
    r = 8'($random(seed));
    m = 8'($random(seed));
    cld_host_inst.strb = 4'($random(seed)) & 4'hE;
    cld_host_inst.wr(32'hC, 32'hFF, 2'h0);
    cld_host_inst.rd(32'hC, 34'h0);
    cld_host_inst.strb = 4'($random(seed)) | 4'h1;
    cld_host_inst.wr(32'hC, {24'h0, r}, 2'h0);
    monitor_cmp_pin <= m;
    cld_host_inst.settle(200);
    `CHK(diag_current_enable, r)
    cld_host_inst.rd(32'h10, {26'h0, m});
    m = 8'($random(seed));
    monitor_cmp_pin <= m;
    cld_host_inst.settle(5);
    cld_host_inst.rd(32'h10, {26'h0, m});
    cld_host_inst.rd(32'h1C, {33'h0, |(m & r)});
    cld_host_inst.wr(32'hC, 32'h0, 2'h0);
    chan_request <= 8'hFF;
    monitor_cmp_pin <= 8'hFF;
    cld_host_inst.settle(10);
    for (int k = 0; k < 2; k++) begin
      ch = 3'($random(seed));
      if (k == 1) overtemp_pin[ch] <= 1'b1;
      else overload_pin[ch] <= 1'b1;
      cld_host_inst.settle(10);
      {overload_pin, overtemp_pin} <= '0;
      cld_host_inst.settle(10);
      cld_host_inst.rd(32'h4, {33'h0, 1'b1} << ch);
      cld_host_inst.rd(32'h1C, 34'h4);
      cld_host_inst.rd(32'h0, {26'h0, 8'hFF ^ (8'h1 << ch)});
      cld_host_inst.wr(32'h8, 32'h1 << ch, 2'h0);
      cld_host_inst.settle(10);
      cld_host_inst.rd(32'h4, 34'h0);
      cld_host_inst.rd(32'h0, 34'hFF);
    end
    cld_host_inst.wr(32'h20, 32'hFF, 2'h0);
    for (int c = 2; c < 8; c++) begin
      ll = 8'($random(seed));
      load_current_low_pin <= ll;
      cld_host_inst.wr(32'h14, c, 2'h0);
      cld_host_inst.settle(510);
      cld_host_inst.rd(32'h18, {33'h0, ll[c]} << c);
      cld_host_inst.rd(32'h1C, {32'h0, ll[c], 1'b0});
      ll[c] = ~ll[c];
      load_current_low_pin <= ll;
      cld_host_inst.settle(5);
      cld_host_inst.rd(32'h18, {33'h0, ll[c]} << c);
      cld_host_inst.rd(32'h18, {33'h0, ll[c]} << c);
      `CHK(mux_channel, 3'(c))
    end
    load_current_low_pin <= 8'hFF;
    cld_host_inst.wr(32'h20, 32'h7F, 2'h0);
    cld_host_inst.settle(5);
    cld_host_inst.rd(32'h18, 34'h0);
    `CHK(mux_enable, 1'b0)
    cld_host_inst.wr(32'h14, 32'h9, 2'h0);
    cld_host_inst.rd(32'h1C, 34'h0);
    // fallback: hold an overload so every restart fails again
    chan_request <= 8'h01;
    overload_pin <= 8'h01;
    {fallback_pin, fallback_in_pin} <= 2'b11;
    edges.delete();
    while (edges.size() < 27) @(posedge aclk);
    for (int k = 1; k < 27; k++) begin
      `CHK(gap_ok(edges[k] - edges[k-1], RC << (k / 8)), 1'b1)
    end
    fallback_in_pin <= 1'b0;
    cld_host_inst.settle(5);
    edges.delete();
    fallback_in_pin <= 1'b1;
    while (edges.size() < 3) @(posedge aclk);
    `CHK(gap_ok(edges[1] - edges[0], RC), 1'b1)
    `CHK(gap_ok(edges[2] - edges[1], RC), 1'b1)
    wrap_up();
  end
endmodule // test_cld_top
`default_nettype wire
